//--- logic/wsb_pkg.sv
package wsb_pkg;
    // frame bytes
    localparam logic [7:0] SYNC_BYTE = 8'h55;
    localparam logic [7:0] ID_WIEG = 8'h01;
    localparam logic [7:0] ID_TAMP = 8'h02;
    localparam logic [7:0] ID_AUX0 = 8'h03;
    localparam logic [7:0] ID_AUX1 = 8'h04;
    localparam logic [7:0] TERM_BYTE = 8'h0D;
    localparam logic [7:0] RSVD_BYTE = 8'h00;
    localparam logic [7:0] LEVEL_LO = 8'h00;
    localparam logic [7:0] LEVEL_HI = 8'hFF;
    // frame sizes and bit count limits
    localparam int FRAME_BYTES = 20;
    localparam int FRAME_W = 160;
    localparam logic [4:0] LAST_IDX_WIEG = 5'h13;
    localparam logic [4:0] LAST_IDX_SHORT = 5'h05;
    localparam logic [4:0] LEN_WIEG = 5'h14;
    localparam logic [4:0] LEN_SHORT = 5'h06;
    localparam logic [7:0] BITS_MIN = 8'h06;
    localparam logic [7:0] BITS_MAX = 8'h60;
    localparam int PAYLOAD_W = 96;
    // register map
    localparam logic [3:0] ADDR_STATUS = 4'h0;
    localparam logic [3:0] ADDR_MASK = 4'h4;
    localparam logic [3:0] ADDR_STATE = 4'h8;
    // event bits of status and mask
    localparam int EV_ACCEPT = 0;
    localparam int EV_DISCARD = 1;
    localparam int EV_TXSTART = 2;
    localparam int EV_W = 3;

    // one captured or generated wiegand sequence
    typedef struct packed {
        logic [6:0] nbits;
        logic [95:0] bits;
    } wsb_wframe_s;

    // one serial byte
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } wsb_byte_s;
endpackage

//--- logic/wsb_frame_tx.sv
`timescale 1ns/1ps
// sends a loaded frame byte by byte, top byte first
module wsb_frame_tx #(
    parameter int BYTES = 20
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // frame load
    input wire logic load_i,
    input wire logic [8*BYTES-1:0] frame_i,
    input wire logic [4:0] len_i,
    output logic busy_o,
    // serial byte out
    output logic tx_valid_o,
    output logic [7:0] tx_data_o,
    input wire logic tx_ready_i
);
    import wsb_pkg::*;
    typedef struct packed {
        logic [8*BYTES-1:0] frame;
        logic [4:0] remain;
        logic valid;
    } wsb_tx_state_s;

    wsb_tx_state_s st_reg, st_next;

    if (BYTES < 6 || BYTES > 31) begin : g_chk
        $error("frame size out of range");
    end

    // shift one byte out per accepted transfer
    always_comb begin
        st_next = st_reg;
        if (load_i && !st_reg.valid) begin
            st_next.frame = frame_i;
            st_next.remain = len_i;
            st_next.valid = 1'b1;
        end else if (st_reg.valid && tx_ready_i) begin
            st_next.frame = {st_reg.frame[8*BYTES-9:0], 8'h00};
            st_next.remain = st_reg.remain - 5'h01;
            st_next.valid = (st_reg.remain != 5'h01);
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign busy_o = st_reg.valid;
    assign tx_valid_o = st_reg.valid;
    assign tx_data_o = st_reg.frame[8*BYTES-1 -: 8];
endmodule // wsb_frame_tx

//--- logic/wsb_bridge.sv
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/1ps
//Contract
// [R1] input mode: each complete captured wiegand sequence is sent as a frame command
// [R2] output mode: a received frame command produces the matching wiegand sequence
// [R3] frame command is 20 bytes: two sync, id 01h, bit count, then rest
// [R4] bit count includes parity and must lie between 6 and 96
// [R5] payload carries all wiegand bits, parity included, unchanged
// [R6] pulse-width and bit-period bytes are accepted but do not alter timing
// [R7] byte 1 is reserved, byte 0 is carriage return 0Dh
// [R8] the wiegand source leaves an idle gap between frames
// [R9] input mode: each tamper input change sends a tamper command, id 02h
// [R10] output mode: tamper command sets tamper output to the encoded level
// [R11] short commands are six bytes; value 00h is low, FFh is high
// [R12] input mode: commands 03h and 04h set aux line zero or one
// [R13] output mode: each aux line zero change is reported
// [R14] output mode: each aux line one change is reported
// [R15] aux line zero value 00h means low, FFh means high
// [R16] frames go out most significant byte first, sync first
// [R17] input mode: both aux lines are outputs under host control
// [R18] first received bit sits in payload msb; unused bits are zero
// [R19] bad sync, id, bit count or terminator drops the frame silently
module wsb_bridge
    import wsb_pkg::*;
#(
    parameter logic [7:0] PULSE_CODE = 8'h00,
    parameter logic [7:0] PERIOD_CODE = 8'h00
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // mode strap pin, high selects input mode
    input wire logic mode_i,
    // serial byte stream from and to the host uart
    input wire wsb_pkg::wsb_byte_s rx_i,
    output logic tx_valid_o,
    output logic [7:0] tx_data_o,
    input wire logic tx_ready_i,
    // wiegand capture strobes
    input wire logic wg_bit_valid_i,
    input wire logic wg_bit_i,
    input wire logic wg_done_i,
    // wiegand sequence to generate
    output logic wg_out_valid_o,
    output wsb_pkg::wsb_wframe_s wg_out_o,
    // tamper pins
    input wire logic tamper_in_i,
    output logic tamper_out_o,
    // aux two-way pins
    input wire logic [1:0] aux_in_i,
    output logic [1:0] aux_out_o,
    output logic [1:0] aux_oe_o,
    // register port
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    output logic irq_o
);
    import wsb_pkg::*;

    // all bridge state except the byte serialiser in one record
    typedef struct packed {
        logic tsy1, tsy2, tprev;
        logic [1:0] asy1, asy2, aprev;
        logic msy1, msy2;
        logic [4:0] rx_idx;
        logic [7:0] rx_id;
        logic [FRAME_W-1:0] rx_buf;
        logic [PAYLOAD_W-1:0] cap_bits;
        logic [6:0] cap_cnt;
        logic cap_full;
        logic pend_t;
        logic [1:0] pend_a;
        logic tamp_out;
        logic [1:0] aux_out;
        logic [1:0] aux_oe;
        wsb_wframe_s wo;
        logic wo_valid;
        logic tx_load;
        logic [FRAME_W-1:0] tx_frame;
        logic [4:0] tx_len;
        logic [EV_W-1:0] sts, msk;
        logic irq;
        logic [7:0] rdata;
    } wsb_state_s;

    // registered state and its next value
    wsb_state_s s_reg, s_next;

    logic in_mode, t_chg, tx_busy, can_load;
    logic [1:0] a_chg;
    logic [FRAME_W-1:0] nbuf;
    logic [7:0] cnt_byte, val_byte;
    logic rx_fin, id_ok, cnt_ok, val_ok, rx_good, rx_disc;
    logic acc_w, acc_t, acc_a0, acc_a1;
    logic [EV_W-1:0] ev;

    // change detection on synchronised pins
    assign in_mode = s_reg.msy2;
    assign t_chg = s_reg.tsy2 ^ s_reg.tprev;
    assign a_chg = s_reg.asy2 ^ s_reg.aprev;

    // receive frame checks
    assign nbuf = {s_reg.rx_buf[FRAME_W-9:0], rx_i.data};
    assign cnt_byte = nbuf[135:128];
    assign val_byte = nbuf[23:16];
    assign id_ok = (rx_i.data >= ID_WIEG) && (rx_i.data <= ID_AUX1);
    assign cnt_ok = (cnt_byte >= BITS_MIN) && (cnt_byte <= BITS_MAX); // R4
    assign val_ok = (val_byte == LEVEL_LO) || (val_byte == LEVEL_HI); // R11 R15
    assign rx_fin = rx_i.valid && (s_reg.rx_idx ==
        ((s_reg.rx_id == ID_WIEG) ? LAST_IDX_WIEG : LAST_IDX_SHORT));
    assign rx_good = rx_fin && (nbuf[7:0] == TERM_BYTE) // R7
        && ((s_reg.rx_id == ID_WIEG) ? cnt_ok : val_ok);
    assign rx_disc = (rx_i.valid && s_reg.rx_idx == 5'h02 && !id_ok)
        || (rx_fin && !rx_good); // R19

    // commands that act in the present mode
    assign acc_w = rx_good && s_reg.rx_id == ID_WIEG && !in_mode; // R2
    assign acc_t = rx_good && s_reg.rx_id == ID_TAMP && !in_mode; // R10
    assign acc_a0 = rx_good && s_reg.rx_id == ID_AUX0 && in_mode; // R12
    assign acc_a1 = rx_good && s_reg.rx_id == ID_AUX1 && in_mode; // R12

    // a new frame loads only when the serialiser is idle
    assign can_load = !tx_busy && !s_reg.tx_load;
    // event bits for the status register
    assign ev[EV_ACCEPT] = rx_good;
    assign ev[EV_DISCARD] = rx_disc;
    assign ev[EV_TXSTART] = can_load && (s_reg.cap_full || s_reg.pend_t || (|s_reg.pend_a));

    // next state of the whole bridge
    always_comb begin
        s_next = s_reg;
        s_next.tsy1 = tamper_in_i;
        s_next.tsy2 = s_reg.tsy1;
        s_next.tprev = s_reg.tsy2;
        s_next.asy1 = aux_in_i;
        s_next.asy2 = s_reg.asy1;
        s_next.aprev = s_reg.asy2;
        s_next.msy1 = mode_i;
        s_next.msy2 = s_reg.msy1;
        s_next.aux_oe = {2{in_mode}}; // R17
        s_next.wo_valid = 1'b0;
        s_next.tx_load = 1'b0;
        s_next.rdata = 8'h00;

        // serial frame parser, sync bytes first
        if (rx_i.valid) begin
            s_next.rx_buf = nbuf;
            case (s_reg.rx_idx)
                5'h00: s_next.rx_idx = (rx_i.data == SYNC_BYTE) ? 5'h01 : 5'h00;
                5'h01: s_next.rx_idx = (rx_i.data == SYNC_BYTE) ? 5'h02 : 5'h00;
                5'h02: begin
                    s_next.rx_id = rx_i.data;
                    s_next.rx_idx = id_ok ? 5'h03 : 5'h00; // R19
                end
                default: s_next.rx_idx = rx_fin ? 5'h00 : s_reg.rx_idx + 5'h01;
            endcase
        end

        // act on a good command; timing bytes are not used
        if (acc_w) begin
            s_next.wo_valid = 1'b1; // R2 R6
            s_next.wo.nbits = cnt_byte[6:0];
            s_next.wo.bits = nbuf[127:32]; // R5
        end
        if (acc_t) begin
            s_next.tamp_out = (val_byte == LEVEL_HI); // R10
        end
        if (acc_a0) begin
            s_next.aux_out[0] = (val_byte == LEVEL_HI); // R12 R15
        end
        if (acc_a1) begin
            s_next.aux_out[1] = (val_byte == LEVEL_HI); // R12
        end

        // wiegand capture, held while a frame waits to go out
        if (!s_reg.cap_full) begin
            if (wg_done_i) begin
                if (in_mode && {1'b0, s_reg.cap_cnt} >= BITS_MIN
                    && {1'b0, s_reg.cap_cnt} <= BITS_MAX) begin
                    s_next.cap_full = 1'b1; // R1
                end else begin
                    s_next.cap_cnt = 7'h00;
                    s_next.cap_bits = '0;
                end
            end else if (wg_bit_valid_i && {1'b0, s_reg.cap_cnt} < BITS_MAX) begin
                s_next.cap_bits[7'h5F - s_reg.cap_cnt] = wg_bit_i; // R18
                s_next.cap_cnt = s_reg.cap_cnt + 7'h01;
            end
        end

        // transmit arbiter, one frame at a time
        if (can_load) begin
            if (s_reg.cap_full) begin
                s_next.tx_load = 1'b1; // R1
                s_next.tx_len = LEN_WIEG;
                s_next.tx_frame = {SYNC_BYTE, SYNC_BYTE, ID_WIEG, // R3 R16
                    1'b0, s_reg.cap_cnt, s_reg.cap_bits, // R5
                    PULSE_CODE, PERIOD_CODE, RSVD_BYTE, TERM_BYTE}; // R6 R7
                s_next.cap_full = 1'b0; // R8
                s_next.cap_cnt = 7'h00;
                s_next.cap_bits = '0; // R18
            end else if (s_reg.pend_t || (|s_reg.pend_a)) begin
                s_next.tx_load = 1'b1;
                s_next.tx_len = LEN_SHORT;
                s_next.tx_frame[FRAME_W-49:0] = '0;
                if (s_reg.pend_t) begin
                    s_next.pend_t = 1'b0;
                    s_next.tx_frame[FRAME_W-1 -: 48] = {SYNC_BYTE, SYNC_BYTE,
                        ID_TAMP, s_reg.tsy2 ? LEVEL_HI : LEVEL_LO,
                        RSVD_BYTE, TERM_BYTE}; // R9 R11
                end else if (s_reg.pend_a[0]) begin
                    s_next.pend_a[0] = 1'b0;
                    s_next.tx_frame[FRAME_W-1 -: 48] = {SYNC_BYTE, SYNC_BYTE,
                        ID_AUX0, s_reg.asy2[0] ? LEVEL_HI : LEVEL_LO,
                        RSVD_BYTE, TERM_BYTE}; // R13 R15
                end else begin
                    s_next.pend_a[1] = 1'b0;
                    s_next.tx_frame[FRAME_W-1 -: 48] = {SYNC_BYTE, SYNC_BYTE,
                        ID_AUX1, s_reg.asy2[1] ? LEVEL_HI : LEVEL_LO,
                        RSVD_BYTE, TERM_BYTE}; // R14
                end
            end
        end

        // pin changes raise reports; set after clear so none is lost
        if (in_mode && t_chg) begin
            s_next.pend_t = 1'b1; // R9
        end
        if (!in_mode) begin
            s_next.pend_a = s_next.pend_a | a_chg; // R13 R14
        end else begin
            s_next.pend_a = 2'b00;
        end
        if (!in_mode) begin
            s_next.pend_t = 1'b0;
        end

        // register port, write one to clear status
        if (wr_i && addr_i == ADDR_STATUS) begin
            s_next.sts = s_reg.sts & ~wdata_i[EV_W-1:0];
        end
        if (wr_i && addr_i == ADDR_MASK) begin
            s_next.msk = wdata_i[EV_W-1:0];
        end
        s_next.sts = s_next.sts | ev;
        if (rd_i) begin
            case (addr_i)
                ADDR_STATUS: s_next.rdata = {5'h00, s_reg.sts};
                ADDR_MASK: s_next.rdata = {5'h00, s_reg.msk};
                ADDR_STATE: s_next.rdata = {in_mode, s_reg.tamp_out,
                    s_reg.aux_out, s_reg.tsy2, s_reg.asy2, s_reg.cap_full};
                default: s_next.rdata = 8'h00;
            endcase
        end
        s_next.irq = |(s_next.sts & s_next.msk);
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // byte serialiser
    wsb_frame_tx #(
        .BYTES(FRAME_BYTES)
    ) u_tx (
        .mclk_i(mclk_i),
        .reset_i(reset_i),
        .load_i(s_reg.tx_load),
        .frame_i(s_reg.tx_frame),
        .len_i(s_reg.tx_len),
        .busy_o(tx_busy),
        .tx_valid_o(tx_valid_o),
        .tx_data_o(tx_data_o),
        .tx_ready_i(tx_ready_i)
    );

    // outputs from state flops
    assign wg_out_valid_o = s_reg.wo_valid;
    assign wg_out_o = s_reg.wo;
    assign tamper_out_o = s_reg.tamp_out;
    assign aux_out_o = s_reg.aux_out;
    assign aux_oe_o = s_reg.aux_oe;
    assign rdata_o = s_reg.rdata;
    assign irq_o = s_reg.irq;

    // checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);

    // command and capture checks
    a_wiegand_out_gen: assert property (acc_w |=> wg_out_valid_o // R2
        && wg_out_o.bits == $past(nbuf[127:32]))
        else $error("wiegand output not generated from frame");
    a_tamper_out_set: assert property (acc_t |=> // R10
        tamper_out_o == ($past(val_byte) == LEVEL_HI))
        else $error("tamper output level wrong");
    a_aux_out_set: assert property (acc_a0 |=> // R12
        aux_out_o[0] == ($past(val_byte) == LEVEL_HI))
        else $error("aux line zero level wrong");
    a_aux_dir_input: assert property (in_mode |=> aux_oe_o == 2'b11) // R17
        else $error("aux lines not driven in input mode");
    a_tx_first_sync: assert property ($rose(tx_valid_o) |-> tx_data_o == SYNC_BYTE) // R16
        else $error("frame does not start with sync");
    a_tamper_report: assert property (in_mode && t_chg |=> s_reg.pend_t) // R9
        else $error("tamper change not queued");
    a_discard_quiet: assert property (rx_disc |=> !wg_out_valid_o // R19
        && $stable(tamper_out_o) && $stable(aux_out_o))
        else $error("discarded frame changed outputs");
    a_capture_msb: assert property (wg_bit_valid_i && !wg_done_i && !s_reg.cap_full // R18
        && s_reg.cap_cnt == 7'h00 |=> s_reg.cap_bits[95] == $past(wg_bit_i))
        else $error("first bit not in payload msb");
    a_bits_range: assert property (wg_out_valid_o |-> wg_out_o.nbits >= 7'h06 // R4
        && wg_out_o.nbits <= 7'h60)
        else $error("generated bit count out of range");

    // transmit and report checks
    a_wiegand_frame_load: assert property (s_reg.cap_full && can_load |=> s_reg.tx_load // R1 R3
        && s_reg.tx_len == LEN_WIEG && s_reg.tx_frame[7:0] == TERM_BYTE
        && s_reg.tx_frame[FRAME_W-1 -: 24] == {SYNC_BYTE, SYNC_BYTE, ID_WIEG})
        else $error("wiegand frame not loaded for transmit");
    a_tx_hold: assert property (tx_valid_o && !tx_ready_i |=> // R16
        tx_valid_o && $stable(tx_data_o))
        else $error("serial byte changed before it was taken");
    a_aux_report: assert property (!in_mode && (|a_chg) |=> // R13 R14
        (s_reg.pend_a & $past(a_chg)) == $past(a_chg))
        else $error("aux line change not queued");
    a_term_discard: assert property (rx_fin && rx_i.data != TERM_BYTE |-> rx_disc) // R7
        else $error("frame without terminator not discarded");

    // main scenarios reached
    c_wiegand_out: cover property (wg_out_valid_o);
    c_aux_report: cover property (s_reg.tx_load && s_reg.tx_frame[143:136] == ID_AUX1);
    c_tamper_sent: cover property (s_reg.tx_load && s_reg.tx_frame[143:136] == ID_TAMP);
    c_discard: cover property (rx_disc);
    c_irq: cover property ($rose(irq_o));
endmodule // wsb_bridge

//--- test/wsb_host_model.sv
`timescale 1ns/1ps
// host uart: takes frame bytes, stalling every other cycle when slow
module wsb_host_model (
    // clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // byte stream from the bridge
    input wire logic tx_valid_i,
    input wire logic [7:0] tx_data_i,
    output logic tx_ready_o,
    // stall control from the bench
    input wire logic slow_i
);
    logic [7:0] got[$];

    // ready pattern, changed just after the edge
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            tx_ready_o <= 1'b0;
        end else begin
            tx_ready_o <= slow_i ? ~tx_ready_o : 1'b1;
        end
    end

    // bytes kept in arrival order, top byte first
    always @(posedge mclk_i) begin
        if (!reset_i && tx_valid_i === 1'b1 && tx_ready_o) begin
            got.push_back(tx_data_i);
        end
    end
endmodule // wsb_host_model

//--- test/tb_wiegand_serial_command_bridge.sv
`timescale 1ns/1ps
// self-checking bench for the serial command bridge
module tb_wiegand_serial_command_bridge;
    import wsb_pkg::*;
    typedef logic [7:0] wsb_bytes_t[$];
    logic mclk_i, reset_i, mode_i, tx_valid_o, tx_ready_i, slow;
    logic wg_bit_valid_i, wg_bit_i, wg_done_i, wg_out_valid_o;
    logic tamper_in_i, tamper_out_o, wr_i, rd_i, irq_o;
    logic [1:0] aux_in_i, aux_out_o, aux_oe_o;
    logic [3:0] addr_i;
    logic [7:0] wdata_i, rdata_o, tx_data_o, d;
    wsb_byte_s rx_i;
    wsb_wframe_s wg_out_o, wg_last;
    int errors = 0;
    int samples_checked = 0;
    int wg_cnt = 0;
    int cyc = 0;

    wsb_bridge i_wsb_bridge (.mclk_i(mclk_i), .reset_i(reset_i), .mode_i(mode_i), .rx_i(rx_i),
        .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i),
        .wg_bit_valid_i(wg_bit_valid_i), .wg_bit_i(wg_bit_i), .wg_done_i(wg_done_i),
        .wg_out_valid_o(wg_out_valid_o), .wg_out_o(wg_out_o), .tamper_in_i(tamper_in_i),
        .tamper_out_o(tamper_out_o), .aux_in_i(aux_in_i), .aux_out_o(aux_out_o),
        .aux_oe_o(aux_oe_o), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .irq_o(irq_o));
    wsb_host_model i_wsb_host_model (.mclk_i(mclk_i), .reset_i(reset_i),
        .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o), .tx_ready_o(tx_ready_i), .slow_i(slow));

    // clock, and the hang limit
    initial begin
        mclk_i = 1'b0;
        forever #2 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i) begin
        cyc++;
        if (wg_out_valid_o === 1'b1) begin
            wg_cnt++;
            wg_last = wg_out_o;
        end
        if (cyc == 20000) begin
            errors++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t byte %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk96(input logic [95:0] got, input logic [95:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t bits %h expected %h", $time, got, exp);
        end
    endtask

    // frame builders, top byte first
    function automatic wsb_bytes_t wf(input logic [7:0] cnt, input logic [95:0] p,
                                      input logic [7:0] pw, input logic [7:0] bp);
        wsb_bytes_t q;
        q = '{SYNC_BYTE, SYNC_BYTE, ID_WIEG, cnt};
        for (int i = 11; i >= 0; i--) begin
            q.push_back(p[8*i +: 8]);
        end
        q = {q, pw, bp, RSVD_BYTE, TERM_BYTE};
        return q;
    endfunction
    function automatic wsb_bytes_t sc(input logic [7:0] id, input logic [7:0] v);
        return '{SYNC_BYTE, SYNC_BYTE, id, v, RSVD_BYTE, TERM_BYTE};
    endfunction

    task automatic send_rx(input wsb_bytes_t b);
        foreach (b[i]) begin
            @(posedge mclk_i);
            rx_i <= '{valid: 1'b1, data: b[i]};
        end
        @(posedge mclk_i);
        rx_i <= '0;
        repeat (3) @(posedge mclk_i);
        #1;
    endtask

    // waits for the host to collect a frame, then compares it whole
    task automatic exp_frame(input wsb_bytes_t e);
        int n;
        n = 0;
        while (i_wsb_host_model.got.size() < e.size() && n < 800) begin
            @(posedge mclk_i);
            n++;
        end
        repeat (e.size() == 0 ? 60 : 4) @(posedge mclk_i);
        chk8(8'(i_wsb_host_model.got.size()), 8'(e.size()));
        foreach (e[i]) chk8(i_wsb_host_model.got[i], e[i]);
        i_wsb_host_model.got.delete();
    endtask

    task automatic wg_capture(input int n, input logic [25:0] pat);
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge mclk_i);
            wg_bit_valid_i <= 1'b1;
            wg_bit_i <= pat[i];
        end
        @(posedge mclk_i);
        wg_bit_valid_i <= 1'b0;
        wg_done_i <= 1'b1;
        @(posedge mclk_i);
        wg_done_i <= 1'b0;
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask
    task automatic reg_rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1;
        v = rdata_o;
    endtask

    task automatic t_input_mode();
        wsb_bytes_t no_bytes;
        chk8({6'h0, aux_oe_o}, 8'h03);
        wg_capture(26, 26'h2A5F3C1);
        exp_frame(wf(8'h1A, {26'h2A5F3C1, 70'h0}, 8'h00, 8'h00));
        repeat (30) @(posedge mclk_i); // idle gap before the next source frame
        wg_capture(5, 26'h15);
        exp_frame(no_bytes);
        tamper_in_i <= 1'b1;
        exp_frame(sc(ID_TAMP, LEVEL_HI));
        tamper_in_i <= 1'b0;
        exp_frame(sc(ID_TAMP, LEVEL_LO));
        send_rx(sc(ID_AUX0, LEVEL_HI));
        chk8({6'h0, aux_out_o}, 8'h01);
        send_rx(sc(ID_AUX1, LEVEL_HI));
        chk8({6'h0, aux_out_o}, 8'h03);
        send_rx(sc(ID_AUX0, LEVEL_LO));
        chk8({6'h0, aux_out_o}, 8'h02);
        $display("test input_mode done");
    endtask

    task automatic t_discard_irq();
        reg_wr(ADDR_STATUS, 8'h07);
        reg_wr(ADDR_MASK, 8'h02);
        send_rx('{SYNC_BYTE, SYNC_BYTE, ID_AUX1, LEVEL_LO, RSVD_BYTE, 8'h0A});
        chk8({6'h0, aux_out_o}, 8'h02);
        chk8({7'h0, irq_o}, 8'h01);
        reg_rd(ADDR_STATUS, d);
        chk8(d & 8'h03, 8'h02);
        reg_wr(ADDR_STATUS, 8'h02);
        @(posedge mclk_i);
        #1;
        chk8({7'h0, irq_o}, 8'h00);
        reg_rd(4'hC, d);
        chk8(d, 8'h00);
        reg_rd(ADDR_STATE, d);
        chk8(d, 8'hA0);
        $display("test discard_irq done");
    endtask

    task automatic t_output_mode();
        mode_i <= 1'b0;
        repeat (10) @(posedge mclk_i);
        chk8({6'h0, aux_oe_o}, 8'h00);
        send_rx(wf(8'h60, 96'hC3A5_0F1E_7788_99AB_CDEF_0123, 8'h3C, 8'hA7));
        chk8(8'(wg_cnt), 8'h01);
        chk96(wg_last.bits, 96'hC3A5_0F1E_7788_99AB_CDEF_0123);
        chk8({1'b0, wg_last.nbits}, 8'h60);
        send_rx(wf(8'h61, 96'h1, 8'h00, 8'h00));
        chk8(8'(wg_cnt), 8'h01);
        send_rx(wf(8'h06, 96'hFC00_0000_0000_0000_0000_0000, 8'h11, 8'h22));
        chk8({1'b0, wg_last.nbits}, 8'h06);
        send_rx(sc(ID_TAMP, LEVEL_HI));
        chk8({7'h0, tamper_out_o}, 8'h01);
        send_rx(sc(ID_TAMP, 8'h5A));
        chk8({7'h0, tamper_out_o}, 8'h01);
        send_rx(sc(ID_TAMP, LEVEL_LO));
        chk8({7'h0, tamper_out_o}, 8'h00);
        slow <= 1'b1;
        aux_in_i <= 2'b01;
        exp_frame(sc(ID_AUX0, LEVEL_HI));
        aux_in_i <= 2'b11;
        exp_frame(sc(ID_AUX1, LEVEL_HI));
        aux_in_i <= 2'b10;
        exp_frame(sc(ID_AUX0, LEVEL_LO));
        slow <= 1'b0;
        $display("test output_mode done");
    endtask

    // reset, then the scenarios in turn
    initial begin
        reset_i = 1'b1;
        mode_i = 1'b1;
        slow = 1'b0;
        rx_i = '0;
        {wg_bit_valid_i, wg_bit_i, wg_done_i, tamper_in_i, wr_i, rd_i} = '0;
        aux_in_i = 2'b00;
        addr_i = 4'h0;
        wdata_i = 8'h00;
        repeat (6) @(posedge mclk_i);
        reset_i <= 1'b0;
        repeat (8) @(posedge mclk_i);
        t_input_mode();
        t_discard_irq();
        t_output_mode();
        give_verdict();
    end
endmodule // tb_wiegand_serial_command_bridge
